/* File: ebtcs_cfg.svh */
`ifndef EBTCS_CFG_SVH
`define EBTCS_CFG_SVH

// ****************************************
// register map: address[7:5] channel, [4:2] register
// ****************************************
`define EBTCS_R_CTL      3'h0
`define EBTCS_R_STAT     3'h1
`define EBTCS_R_CMPA     3'h2
`define EBTCS_R_CMPB     3'h3
`define EBTCS_R_CNT      3'h4
`define EBTCS_R_CKX      3'h5
`define EBTCS_CH_COM     3'h4
`define EBTCS_R_SYS      3'h0
`define EBTCS_R_PAIR     3'h1

// ****************************************
// field positions
// ****************************************
`define EBTCS_F_MIEB     7
`define EBTCS_F_MIEA     6
`define EBTCS_F_WIE      5
`define EBTCS_F_WRAP     5
`define EBTCS_F_BIT4     4
`define EBTCS_F_ALT      3
`define EBTCS_F_PAIR_CLOCK_SEL_X     5
`define EBTCS_F_PAIR_CLOCK_SEL_Y     4

// ****************************************
// reset values
// ****************************************
`define EBTCS_RST_CTL    8'h00
`define EBTCS_RST_CMP    8'hFF
`define EBTCS_RST_CKX    8'hF0
`define EBTCS_PAIR_ONES  8'hCF

// ****************************************
// prescaler taps as log2 of the divide ratio
// ****************************************
`define EBTCS_PRE_W      14
`define EBTCS_LG_D1      4'h0
`define EBTCS_LG_D2      4'h1
`define EBTCS_LG_D4      4'h2
`define EBTCS_LG_D8      4'h3
`define EBTCS_LG_D32     4'h5
`define EBTCS_LG_D64     4'h6
`define EBTCS_LG_D128    4'h7
`define EBTCS_LG_D256    4'h8
`define EBTCS_LG_D1024   4'hA
`define EBTCS_LG_D2048   4'hB
`define EBTCS_LG_D4096   4'hC
`define EBTCS_LG_D8192   4'hD
`define EBTCS_LG_D16384  4'hE

`endif

/* File: ebtcs_chan.sv */
`default_nettype none

module ebtcs_chan #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         count_en,
  input  wire logic         cnt_wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] cmp_a,
  input  wire logic [W-1:0] cmp_b,
  input  wire logic [3:0]   out_act,
  output logic      [W-1:0] cnt,
  output logic              match_a,
  output logic              match_b,
  output logic              wrap,
  output logic              pin
);

  function automatic logic act_pin(input logic cur, input logic [1:0] act);
    case (act)
      2'h0:    act_pin = cur;
      2'h1:    act_pin = 1'b0;
      2'h2:    act_pin = 1'b1;
      2'h3:    act_pin = ~cur;
      default: act_pin = cur;
    endcase
  endfunction : act_pin

  // ****************************************
  // match events in the last equal cycle
  // ****************************************
  assign match_a = count_en && (cnt == cmp_a);
  assign match_b = count_en && (cnt == cmp_b);
  assign wrap    = count_en && (&cnt);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (cnt_wr) begin
      cnt <= wdata;
    end else if (count_en) begin
      cnt <= W'(cnt + 1'b1);
    end
  end

  // ****************************************
  // output pin, action a applied after b
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin <= 1'b0;
    end else if (match_a) begin
      pin <= act_pin(match_b ? act_pin(pin, out_act[3:2]) : pin,
                     out_act[1:0]);
    end else if (match_b) begin
      pin <= act_pin(pin, out_act[3:2]);
    end
  end

endmodule : ebtcs_chan

`default_nettype wire

/* File: ebtcs_pkg.sv */
`default_nettype none

package ebtcs_pkg;
  typedef logic [7:0] ebtcs_byte_t;
  typedef logic [2:0] ebtcs_flags_t;
  typedef enum logic {
    CAP_IDLE,
    CAP_HIGH
  } ebtcs_cap_state_t;
endpackage : ebtcs_pkg

`default_nettype wire

/* File: ebtcs_top.sv */
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`include "ebtcs_cfg.svh"
`default_nettype none

// ****************************************
// Behaviour
// - ch0/1 source from 3-bit select plus prescale alt bit
// - ch0: 000 stop; 001-011 phi/8,64,1024 or phi/2,32,256
// - ch0 code 100 counts ch1 wraps
// - ch1: 000 stop; 001-011 phi/8,64,1024 or phi/2,128,2048
// - ch1 code 100 counts ch0 match a events
// - codes 101,110,111 count external rising, falling, both edges
// - system prescale bit and clock extension bit 3 are one value
// - chY alt 0: phi/4,256,2048; codes 000 and 100 stop
// - chY alt 1: phi/4096,8192,16384; 100 counts chX wraps
// - chX: phi,2,4 or phi/2048,4096,8192; 100 stops or Y match a
// - flag bit 7 on match b, bit 6 on match a
// - flags clear only by write 0 after reading 1
// - bit 5 wrap flag set on counter FF to 00
// - ch0 bit 4 enables adc start on ch0 match a
// - match b drives pin per bits 3:2
// - match a drives pin per bits 1:0
// - ch1 status bit 4 reads 1, ignores writes
// - chY bit 4 gates capture request from chX capture flag
// - chX bit 4 set on external reset rise then fall
// - irq request only when enable bit and flag both set
// - match event in last equal cycle, with counter update
// ****************************************

module ebtcs_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [3:0]  ext_clk,
  input  wire logic        ext_reset_x,
  output logic      [3:0]  timer_out,
  output logic      [3:0]  match_a_irq,
  output logic      [3:0]  match_b_irq,
  output logic      [3:0]  wrap_irq,
  output logic             capture_irq,
  output logic             adc_start
);

  function automatic logic div_tick(input logic [`EBTCS_PRE_W-1:0] p,
                                    input logic [3:0] lg);
    logic [`EBTCS_PRE_W-1:0] m;
    m = `EBTCS_PRE_W'((15'h1 << lg) - 15'h1);
    div_tick = ((p & m) == m);
  endfunction : div_tick

  function automatic logic src_pick(input logic [2:0] cks,
                                    input logic tk,
                                    input logic casc,
                                    input logic rise,
                                    input logic fall);
    case (cks)
      3'h1, 3'h2, 3'h3: src_pick = tk;
      3'h4:             src_pick = casc;
      3'h5:             src_pick = rise;
      3'h6:             src_pick = fall;
      3'h7:             src_pick = rise | fall;
      default:          src_pick = 1'b0;
    endcase
  endfunction : src_pick

  // ****************************************
  // storage
  // ****************************************
  ebtcs_pkg::ebtcs_byte_t  ctl     [4];
  ebtcs_pkg::ebtcs_byte_t  cmp_a   [4];
  ebtcs_pkg::ebtcs_byte_t  cmp_b   [4];
  logic [3:0]              out_act [4];
  ebtcs_pkg::ebtcs_flags_t flags   [4];
  ebtcs_pkg::ebtcs_flags_t armed   [4];
  ebtcs_pkg::ebtcs_byte_t  ckx_rsv [2];
  ebtcs_pkg::ebtcs_byte_t  cnt     [4];
  ebtcs_pkg::ebtcs_cap_state_t cap_st;
  logic [1:0]              alt;
  logic                    adc_trigger_enable;
  logic                    capture_irq_enable;
  logic                    capture_flag;
  logic                    cap_armed;
  logic                    pair_clock_sel_x;
  logic                    pair_clock_sel_y;
  logic [`EBTCS_PRE_W-1:0] pre;
  logic [3:0]              ext_prev;
  logic                    xrst_prev;
  logic [3:0]              en_q;
  logic [3:0]              wrap_q;
  logic [3:0]              cma_q;
  logic [3:0]              next_en;
  logic [3:0]              m_a;
  logic [3:0]              m_b;
  logic [3:0]              wr;
  logic [3:0]              pin;
  logic [3:0]              rise;
  logic [3:0]              fall;
  logic [3:0]              tk;
  logic [3:0]              st_rd;
  logic [3:0]              st_wr;
  logic [2:0]              ch;
  logic [2:0]              rg;
  logic                    do_wr;
  logic                    do_rd;
  ebtcs_pkg::ebtcs_byte_t  wd;
  ebtcs_pkg::ebtcs_byte_t  rd_byte;

  assign ch    = address[7:5];
  assign rg    = address[4:2];
  assign wd    = writedata[7:0];
  assign do_wr = write & ~waitrequest & byteenable[0];
  assign do_rd = read & ~waitrequest;
  assign rise  = ext_clk & ~ext_prev;
  assign fall  = ~ext_clk & ext_prev;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      st_rd[c] = do_rd && (ch == 3'(c)) && (rg == `EBTCS_R_STAT);
      st_wr[c] = do_wr && (ch == 3'(c)) && (rg == `EBTCS_R_STAT);
    end
  end

  // ****************************************
  // prescaler and edge history
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre <= '0;
    end else begin
      pre <= `EBTCS_PRE_W'(pre + 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_prev  <= 4'h0;
      xrst_prev <= 1'b0;
    end else begin
      ext_prev  <= ext_clk;
      xrst_prev <= ext_reset_x;
    end
  end

  // ****************************************
  // count source selection
  // ****************************************
  always_comb begin
    tk[0] = div_tick(pre,
      (ctl[0][1:0] == 2'h1) ? (alt[0] ? `EBTCS_LG_D2 : `EBTCS_LG_D8) :
      (ctl[0][1:0] == 2'h2) ? (alt[0] ? `EBTCS_LG_D32 : `EBTCS_LG_D64) :
      (alt[0] ? `EBTCS_LG_D256 : `EBTCS_LG_D1024));
    tk[1] = div_tick(pre,
      (ctl[1][1:0] == 2'h1) ? (alt[1] ? `EBTCS_LG_D2 : `EBTCS_LG_D8) :
      (ctl[1][1:0] == 2'h2) ? (alt[1] ? `EBTCS_LG_D128 : `EBTCS_LG_D64) :
      (alt[1] ? `EBTCS_LG_D2048 : `EBTCS_LG_D1024));
    tk[2] = div_tick(pre,
      (ctl[2][1:0] == 2'h1) ?
        (pair_clock_sel_y ? `EBTCS_LG_D4096 : `EBTCS_LG_D4) :
      (ctl[2][1:0] == 2'h2) ?
        (pair_clock_sel_y ? `EBTCS_LG_D8192 : `EBTCS_LG_D256) :
      (pair_clock_sel_y ? `EBTCS_LG_D16384 : `EBTCS_LG_D2048));
    tk[3] = div_tick(pre,
      (ctl[3][1:0] == 2'h1) ?
        (pair_clock_sel_x ? `EBTCS_LG_D2048 : `EBTCS_LG_D1) :
      (ctl[3][1:0] == 2'h2) ?
        (pair_clock_sel_x ? `EBTCS_LG_D4096 : `EBTCS_LG_D2) :
      (pair_clock_sel_x ? `EBTCS_LG_D8192 : `EBTCS_LG_D4));
    // cascades use last cycle's events so no loop can form
    next_en[0] = src_pick(ctl[0][2:0], tk[0], wrap_q[1],
                          rise[0], fall[0]);
    next_en[1] = src_pick(ctl[1][2:0], tk[1], cma_q[0],
                          rise[1], fall[1]);
    next_en[2] = src_pick(ctl[2][2:0], tk[2],
                          pair_clock_sel_y & wrap_q[3],
                          rise[2], fall[2]);
    next_en[3] = src_pick(ctl[3][2:0], tk[3],
                          pair_clock_sel_x & cma_q[2],
                          rise[3], fall[3]);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_q   <= 4'h0;
      wrap_q <= 4'h0;
      cma_q  <= 4'h0;
    end else begin
      en_q   <= next_en;
      wrap_q <= wr;
      cma_q  <= m_a;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  for (genvar g = 0; g < 4; g++) begin : g_ch
    ebtcs_chan #(
      .W (8)
    ) u_chan (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .count_en (en_q[g]),
      .cnt_wr   (do_wr && (ch == 3'(g)) && (rg == `EBTCS_R_CNT)),
      .wdata    (wd),
      .cmp_a    (cmp_a[g]),
      .cmp_b    (cmp_b[g]),
      .out_act  (out_act[g]),
      .cnt      (cnt[g]),
      .match_a  (m_a[g]),
      .match_b  (m_b[g]),
      .wrap     (wr[g]),
      .pin      (pin[g])
    );
  end

  assign timer_out = pin;

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int c = 0; c < 4; c++) begin
        ctl[c]     <= `EBTCS_RST_CTL;
        cmp_a[c]   <= `EBTCS_RST_CMP;
        cmp_b[c]   <= `EBTCS_RST_CMP;
        out_act[c] <= 4'h0;
      end
      ckx_rsv[0]         <= `EBTCS_RST_CKX;
      ckx_rsv[1]         <= `EBTCS_RST_CKX;
      adc_trigger_enable <= 1'b0;
      capture_irq_enable <= 1'b0;
      pair_clock_sel_x   <= 1'b0;
      pair_clock_sel_y   <= 1'b0;
    end else if (do_wr) begin
      if (ch < `EBTCS_CH_COM) begin
        case (rg)
          `EBTCS_R_CTL:  ctl[ch[1:0]]   <= wd;
          `EBTCS_R_CMPA: cmp_a[ch[1:0]] <= wd;
          `EBTCS_R_CMPB: cmp_b[ch[1:0]] <= wd;
          `EBTCS_R_STAT: begin
            out_act[ch[1:0]] <= wd[3:0];
            if (ch == 3'h0) begin
              adc_trigger_enable <= wd[`EBTCS_F_BIT4];
            end
            if (ch == 3'h2) begin
              capture_irq_enable <= wd[`EBTCS_F_BIT4];
            end
          end
          `EBTCS_R_CKX: begin
            if (ch < 3'h2) begin
              ckx_rsv[ch[0]] <= wd;
            end
          end
          default: ;
        endcase
      end else if (ch == `EBTCS_CH_COM && rg == `EBTCS_R_PAIR) begin
        pair_clock_sel_x <= wd[`EBTCS_F_PAIR_CLOCK_SEL_X];
        pair_clock_sel_y <= wd[`EBTCS_F_PAIR_CLOCK_SEL_Y];
      end
    end
  end

  // one bit per channel, reached from both places
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alt <= 2'h0;
    end else if (do_wr && ch == `EBTCS_CH_COM && rg == `EBTCS_R_SYS) begin
      alt <= wd[1:0];
    end else if (do_wr && ch < 3'h2 && rg == `EBTCS_R_CKX) begin
      alt[ch[0]] <= wd[`EBTCS_F_ALT];
    end
  end

  // ****************************************
  // status flags: set beats clear
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int c = 0; c < 4; c++) begin
        flags[c] <= 3'h0;
        armed[c] <= 3'h0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        for (int b = 0; b < 3; b++) begin
          if ((b == 2 && m_b[c]) || (b == 1 && m_a[c]) ||
              (b == 0 && wr[c])) begin
            flags[c][b] <= 1'b1;
          end else if (st_wr[c] && !wd[`EBTCS_F_WRAP + b] &&
                       armed[c][b]) begin
            flags[c][b] <= 1'b0;
          end
        end
        if (st_rd[c]) begin
          armed[c] <= readdata[`EBTCS_F_MIEB:`EBTCS_F_WRAP];
        end else if (st_wr[c]) begin
          armed[c] <= 3'h0;
        end
      end
    end
  end

  // ****************************************
  // capture detector on the external reset
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cap_st <= ebtcs_pkg::CAP_IDLE;
    end else begin
      case (cap_st)
        ebtcs_pkg::CAP_IDLE: begin
          if (ext_reset_x && !xrst_prev) begin
            cap_st <= ebtcs_pkg::CAP_HIGH;
          end
        end
        ebtcs_pkg::CAP_HIGH: begin
          if (!ext_reset_x && xrst_prev) begin
            cap_st <= ebtcs_pkg::CAP_IDLE;
          end
        end
        default: cap_st <= ebtcs_pkg::CAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      capture_flag <= 1'b0;
      cap_armed    <= 1'b0;
    end else begin
      if (cap_st == ebtcs_pkg::CAP_HIGH && !ext_reset_x && xrst_prev) begin
        capture_flag <= 1'b1;
      end else if (st_wr[3] && !wd[`EBTCS_F_BIT4] && cap_armed) begin
        capture_flag <= 1'b0;
      end
      if (st_rd[3]) begin
        cap_armed <= readdata[`EBTCS_F_BIT4];
      end else if (st_wr[3]) begin
        cap_armed <= 1'b0;
      end
    end
  end

  // ****************************************
  // requests to the system
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      match_a_irq <= 4'h0;
      match_b_irq <= 4'h0;
      wrap_irq    <= 4'h0;
      capture_irq <= 1'b0;
      adc_start   <= 1'b0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        match_b_irq[c] <= ctl[c][`EBTCS_F_MIEB] & flags[c][2];
        match_a_irq[c] <= ctl[c][`EBTCS_F_MIEA] & flags[c][1];
        wrap_irq[c]    <= ctl[c][`EBTCS_F_WIE] & flags[c][0];
      end
      capture_irq <= capture_irq_enable & capture_flag;
      adc_start   <= adc_trigger_enable & m_a[0];
    end
  end

  // ****************************************
  // avalon slave
  // ****************************************
  always_comb begin
    rd_byte = 8'h00;
    if (ch < `EBTCS_CH_COM) begin
      case (rg)
        `EBTCS_R_CTL:  rd_byte = ctl[ch[1:0]];
        `EBTCS_R_CMPA: rd_byte = cmp_a[ch[1:0]];
        `EBTCS_R_CMPB: rd_byte = cmp_b[ch[1:0]];
        `EBTCS_R_CNT:  rd_byte = cnt[ch[1:0]];
        `EBTCS_R_STAT: begin
          rd_byte = {flags[ch[1:0]], 1'b0, out_act[ch[1:0]]};
          case (ch[1:0])
            2'h0: rd_byte[`EBTCS_F_BIT4] = adc_trigger_enable;
            2'h1: rd_byte[`EBTCS_F_BIT4] = 1'b1;
            2'h2: rd_byte[`EBTCS_F_BIT4] = capture_irq_enable;
            default: rd_byte[`EBTCS_F_BIT4] = capture_flag;
          endcase
        end
        `EBTCS_R_CKX: begin
          if (ch < 3'h2) begin
            rd_byte = ckx_rsv[ch[0]];
            rd_byte[`EBTCS_F_ALT] = alt[ch[0]];
          end
        end
        default: rd_byte = 8'h00;
      endcase
    end else if (ch == `EBTCS_CH_COM) begin
      if (rg == `EBTCS_R_SYS) begin
        rd_byte = {6'h00, alt};
      end else if (rg == `EBTCS_R_PAIR) begin
        rd_byte = `EBTCS_PAIR_ONES;
        rd_byte[`EBTCS_F_PAIR_CLOCK_SEL_X] = pair_clock_sel_x;
        rd_byte[`EBTCS_F_PAIR_CLOCK_SEL_Y] = pair_clock_sel_y;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read & waitrequest) begin
        readdata <= {24'h000000, rd_byte};
      end
    end
  end

endmodule : ebtcs_top

`default_nettype wire

/* File: ebtcs_top_monitor.sv */
`default_nettype none

// ****************************************
// port checker
// ****************************************
module ebtcs_top_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [3:0]  match_a_irq,
  input wire logic [3:0]  match_b_irq,
  input wire logic [3:0]  wrap_irq,
  input wire logic        capture_irq,
  input wire logic [3:0]  timer_out,
  input wire logic        adc_start
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_ack;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");

  property p_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than a cycle");

  property p_st1;
    read && waitrequest && address == 8'h24 |=> readdata[4];
  endproperty
  a_st1: assert property (p_st1) else $error("fixed bit reads 0");

  property p_unm;
    read && waitrequest && address[7:5] > 3'h4 |=> readdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not 0");

  property p_adc;
    adc_start |=> !adc_start;
  endproperty
  a_adc: assert property (p_adc) else $error("adc start too long");

  property p_off;
    write && !waitrequest && byteenable[0] && address == 8'h60 &&
      writedata[7:5] == 3'h0 |-> ##2 !match_a_irq[3] && !match_b_irq[3] &&
      !wrap_irq[3];
  endproperty
  a_off: assert property (p_off) else $error("irq without enable");

  property p_fa;
    $fell(match_a_irq[3]) |-> $past(write, 2) || !$past(rst_n);
  endproperty
  a_fa: assert property (p_fa) else $error("match flag lost");

  property p_fw;
    $fell(wrap_irq[3]) |-> $past(write, 2) || !$past(rst_n);
  endproperty
  a_fw: assert property (p_fw) else $error("wrap flag lost");

  property p_fc;
    $fell(capture_irq) |-> $past(write, 2) || !$past(rst_n);
  endproperty
  a_fc: assert property (p_fc) else $error("capture irq lost");

  c_adc: cover property (adc_start);
  c_cap: cover property (capture_irq);
  c_pin: cover property ($rose(timer_out[3]));
endmodule : ebtcs_top_monitor

`default_nettype wire

/* File: tb_ebtcs_top.sv */
`default_nettype none

module tb_ebtcs_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys, rst_n, read, write, waitrequest, ext_reset_x, p;
  logic        capture_irq, adc_start;
  logic [7:0]  address, rd_v, c0;
  logic [31:0] writedata, readdata, rng;
  logic [3:0]  byteenable, ext_clk, timer_out, match_a_irq, match_b_irq;
  logic [3:0]  wrap_irq;
  logic [7:0]  exp_q[$], msk_q[$];
  int          num_errors, samples_checked, cyc, t_ack, n_adc, a0;
  logic [7:0]  r_a[8] = '{8'h00, 8'h24, 8'h08, 8'h0C, 8'h14, 8'h34, 8'h84,
                          8'hB8};
  logic [7:0]  r_v[8] = '{8'h00, 8'h10, 8'hFF, 8'hFF, 8'hF0, 8'hF0, 8'hCF,
                          8'h00};
  int          t_ch[9] = '{0, 0, 1, 1, 2, 2, 3, 3, 1};
  int          t_cs[9] = '{1, 2, 2, 3, 1, 2, 1, 3, 0};
  int          t_al[9] = '{0, 1, 1, 0, 0, 1, 0, 1, 0};
  int          t_lg[9] = '{3, 5, 7, 10, 2, 13, 0, 13, 31};

  ebtcs_top uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .ext_clk(ext_clk),
    .ext_reset_x(ext_reset_x), .timer_out(timer_out),
    .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
    .wrap_irq(wrap_irq), .capture_irq(capture_irq), .adc_start(adc_start)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [7:0] ra(input int ch, input int ix);
    return 8'(ch * 32 + ix * 4);
  endfunction : ra

  function automatic logic act(input logic [1:0] c, input logic q);
    return c[1] ? (c[0] ? !q : 1'b1) : (c[0] ? 1'b0 : q);
  endfunction : act

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic check_out(input logic [7:0] g, input logic [7:0] e,
                           input string s);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : check_out

  task automatic check_rd(input logic [31:0] g, input logic [7:0] e,
                          input logic [7:0] m);
    samples_checked++;
    if ((g & {24'hFFFFFF, m}) !== {24'h0, e & m}) begin
      num_errors++;
      $display("Error %0t read got %h exp %h", $time, g, e);
    end
  endtask : check_rd

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic be0);
    logic [31:0] r;
    r = xs();
    @(posedge clk_sys);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {r[31:8], d};
    byteenable <= {r[3:1], be0};
    do @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    t_ack = cyc;
    rd_v = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 8'h00, 1'b1);
  endtask : rd

  task automatic rate(input int ch, input int lg);
    logic [7:0] s;
    int         t0;
    rd(ra(ch, 4), 8'h00, 8'h00);
    s = rd_v;
    t0 = t_ack;
    repeat ((lg > 20) ? 97 : ((lg < 3) ? 13 : (2 << lg) - 3))
      @(posedge clk_sys);
    rd(ra(ch, 4), 8'h00, 8'h00);
    check_out(rd_v - s, 8'((t_ack - t0) >> lg), "count rate");
  endtask : rate

  task automatic pulses(input int i, input int k);
    repeat (k) begin
      @(posedge clk_sys);
      ext_clk[i] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_clk[i] <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask : pulses

  task automatic wait_cnt(input logic [7:0] lo);
    int k;
    k = 0;
    do begin
      rd(8'h70, 8'h00, 8'h00);
      k++;
    end while (8'(rd_v - lo) > 8'h1F && k < 200);
  endtask : wait_cnt

  // ****************************************
  // clock, read monitor, timeout
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1)
      n_adc <= n_adc + 1;
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
      check_rd(readdata, exp_q.pop_front(), msk_q.pop_front());
    if (cyc == 80000) begin
      num_errors++;
      $display("Error %0t timeout", $time);
      give_verdict();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {num_errors, samples_checked, cyc, n_adc} = '0;
    rng = 32'hC43C;
    {rst_n, read, write, ext_reset_x, address, writedata} = '0;
    {byteenable, ext_clk} = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
      rd(r_a[i], r_v[i], 8'hFF);
    bus(1'b1, 8'h00, 8'hFF, 1'b0);
    rd(8'h00, 8'h00, 8'hFF);
    wr(8'h24, 8'h00);
    rd(8'h24, 8'h10, 8'h10);
    wr(8'h14, 8'hF8);
    rd(8'h80, 8'h01, 8'h01);
    wr(8'h80, 8'h02);
    rd(8'h34, 8'hF8, 8'hFF);
    rd(8'h14, 8'hF0, 8'hFF);
    $display("registers done");
    for (int i = 0; i < 9; i++) begin
      case (t_ch[i])
        0: wr(8'h14, t_al[i] ? 8'hF8 : 8'hF0);
        1: wr(8'h80, t_al[i] ? 8'h02 : 8'h00);
        2: wr(8'h84, t_al[i] ? 8'hDF : 8'hCF);
        default: wr(8'h84, t_al[i] ? 8'hEF : 8'hCF);
      endcase
      wr(ra(t_ch[i], 0), 8'(t_cs[i]));
      rate(t_ch[i], t_lg[i]);
      wr(ra(t_ch[i], 0), 8'h00);
    end
    wr(8'h80, 8'h02);
    wr(8'h20, 8'h01);
    wr(8'h00, 8'h04);
    rate(0, 9);
    wr(8'h00, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h84, 8'hDF);
    wr(8'h60, 8'h01);
    wr(8'h40, 8'h04);
    rate(2, 8);
    wr(8'h40, 8'h00);
    wr(8'h84, 8'hCF);
    $display("clock sources done");
    for (int c = 5; c < 8; c++) begin
      wr(8'h60, 8'(c));
      rd(8'h70, 8'h00, 8'h00);
      c0 = rd_v;
      pulses(3, 4);
      rd(8'h70, 8'h00, 8'h00);
      check_out(rd_v - c0, (c == 7) ? 8'h08 : 8'h04, "ext edges");
    end
    $display("external clock done");
    wr(8'h08, 8'h02);
    wr(8'h30, 8'h00);
    wr(8'h20, 8'h04);
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, k ? 8'h00 : 8'h10);
      wr(8'h10, 8'h00);
      wr(8'h00, 8'h05);
      a0 = n_adc;
      pulses(0, 3);
      check_out(8'(n_adc - a0), k ? 8'h00 : 8'h01, "adc start");
      rd(8'h30, 8'(k + 1), 8'hFF);
    end
    $display("adc trigger done");
    wr(8'h68, 8'h40);
    wr(8'h6C, 8'hC0);
    wr(8'h60, 8'h01);
    p = 1'b0;
    for (int os = 0; os < 16; os++) begin
      wait_cnt(8'h00);
      wr(8'h64, 8'(os));
      wait_cnt(8'h80);
      p = act(os[1:0], p);
      check_out({7'h0, timer_out[3]}, {7'h0, p}, "pin a");
      wait_cnt(8'hE0);
      p = act(os[3:2], p);
      check_out({7'h0, timer_out[3]}, {7'h0, p}, "pin b");
    end
    $display("pin actions done");
    wr(8'h60, 8'hE0);
    repeat (2) @(posedge clk_sys);
    check_out({5'h0, match_b_irq[3], match_a_irq[3], wrap_irq[3]}, 8'h07,
              "irq on");
    rd(8'h64, 8'hE0, 8'hE0);
    wr(8'h64, 8'hE0);
    wr(8'h64, 8'h00);
    rd(8'h64, 8'hE0, 8'hE0);
    wr(8'h64, 8'h00);
    rd(8'h64, 8'h00, 8'hE0);
    repeat (2) @(posedge clk_sys);
    check_out({5'h0, match_b_irq[3], match_a_irq[3], wrap_irq[3]}, 8'h00,
              "irq off");
    $display("flags done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h44, k ? 8'h00 : 8'h10);
      @(posedge clk_sys);
      ext_reset_x <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_reset_x <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check_out({7'h0, capture_irq}, k ? 8'h00 : 8'h01, "capture");
      rd(8'h64, 8'h10, 8'h10);
      wr(8'h64, 8'h00);
      rd(8'h64, 8'h00, 8'h10);
    end
    $display("capture done");
    give_verdict();
  end
endmodule : tb_ebtcs_top

bind ebtcs_top ebtcs_top_monitor u_mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq),
  .wrap_irq(wrap_irq), .capture_irq(capture_irq), .timer_out(timer_out),
  .adc_start(adc_start)
);

`default_nettype wire
